/* File: ccl_pkg.sv */
// Package for the link configuration and internal error register block.
// Assumes a single core clock domain and word-indexed register access.
package ccl_pkg;

  // -------------------------------------------------------------------
  // Register word indices
  // -------------------------------------------------------------------
  localparam logic [3:0] IDX_CFG_DATA = 4'h0;
  localparam logic [3:0] IDX_PROG_CTL = 4'h1;
  localparam logic [3:0] IDX_UNC_STAT = 4'h2;
  localparam logic [3:0] IDX_UNC_MASK = 4'h3;
  localparam logic [3:0] IDX_COR_STAT = 4'h4;
  localparam logic [3:0] IDX_COR_MASK = 4'h5;

  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  localparam int PROG_REQ_BIT = 0;
  localparam int PROG_START_BIT = 1;
  localparam int UNC_RX_OVF_BIT = 11;
  localparam int UNC_CFG_TX_PAR_BIT = 9;
  localparam int UNC_TX_CFG_PAR_BIT = 8;
  localparam int UNC_TX_TLP_PAR_BIT = 7;
  localparam int UNC_APP_BIT = 6;
  localparam int UNC_LINK_CFG_BIT = 5;
  localparam int UNC_TX_DLL_PAR_BIT = 4;
  localparam int UNC_RX_CFG_PAR_BIT = 3;
  localparam int UNC_RX_BUF_PAR_BIT = 2;
  localparam int UNC_RETRY_ECC_BIT = 1;
  localparam int UNC_RX_ECC_BIT = 0;
  localparam int COR_APP_BIT = 6;
  localparam int COR_LINK_CFG_BIT = 5;
  localparam int COR_RETRY_ECC_BIT = 1;
  localparam int COR_RX_ECC_BIT = 0;

  // -------------------------------------------------------------------
  // Implemented bits and reset values
  // -------------------------------------------------------------------
  localparam logic [31:0] CFG_DATA_RST = 32'h0000_0000;
  localparam logic [31:0] PROG_CTL_BITS = 32'h0000_0003;
  localparam logic [31:0] PROG_CTL_RST = 32'h0000_0000;
  localparam logic [31:0] UNC_STAT_BITS = 32'h0000_0BFF;
  localparam logic [31:0] UNC_MASK_BITS = 32'h0000_0BBF;
  localparam logic [31:0] UNC_MASK_RST = 32'h0000_0B9F;
  localparam logic [31:0] COR_STAT_BITS = 32'h0000_0023;
  localparam logic [31:0] COR_MASK_BITS = 32'h0000_0063;
  localparam logic [31:0] COR_MASK_RST = 32'h0000_0043;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;

  // -------------------------------------------------------------------
  // Clock burst per data write
  // -------------------------------------------------------------------
  localparam int NUMCLK_W = 8;
  localparam int NUMCLK_USED_W = 6;
  localparam logic [6:0] NUMCLK_ZERO_COUNT = 7'h40;

  // Register access request from configuration space.
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [3:0] idx;
    logic [31:0] wrData;
    logic [3:0] byteEn;
  } ccl_req_t;

  // One-cycle error event pulses from the core's detectors.
  typedef struct packed {
    logic rxOverflow;
    logic cfgTxParity;
    logic txCfgParity;
    logic txTlpParity;
    logic appUncorr;
    logic txDllParity;
    logic rxCfgParity;
    logic rxBufParity;
    logic retryUncEcc;
    logic rxUncEcc;
    logic retryCorEcc;
    logic rxCorEcc;
    logic appCorr;
  } ccl_evt_t;

endpackage : ccl_pkg

/* File: ccl_clk_burst.sv */
// Clock burst generator: a run of clock enables per data word write.
// Assumes start is a one-cycle pulse on the same clock as mclk.
module ccl_clk_burst (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic hotReset,
  input wire logic start,
  input wire logic [ccl_pkg::NUMCLK_W-1:0] clocksPerDataWrite,
  output logic burstClk_r
);
  import ccl_pkg::*;

  // -------------------------------------------------------------------
  // State and count
  // -------------------------------------------------------------------
  typedef enum logic [0:0] {
    CCL_IDLE = 1'b0,
    CCL_RUN = 1'b1
  } ccl_burst_t;

  ccl_burst_t state_r;
  ccl_burst_t state_nxt;
  logic [6:0] left_r;
  logic [6:0] left_nxt;
  logic [6:0] loadCount;

  // A field of zero stands for the longest burst; upper bits are unused.
  assign loadCount = (clocksPerDataWrite[NUMCLK_USED_W-1:0] == 6'h00) ?
                     NUMCLK_ZERO_COUNT :
                     {1'b0, clocksPerDataWrite[NUMCLK_USED_W-1:0]};

  // A new write restarts the burst with a fresh count.
  always_comb begin
    state_nxt = state_r;
    left_nxt = left_r;
    case (state_r)
      CCL_IDLE: begin
        if (start) begin
          state_nxt = CCL_RUN;
          left_nxt = loadCount - 7'h01;
        end
      end
      CCL_RUN: begin
        if (start) begin
          left_nxt = loadCount - 7'h01;
        end else if (left_r == 7'h00) begin
          state_nxt = CCL_IDLE;
        end else begin
          left_nxt = left_r - 7'h01;
        end
      end
      default: begin
        state_nxt = CCL_IDLE;
        left_nxt = 7'h00;
      end
    endcase
  end

  // Registers; the output is high one cycle per emitted clock.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= CCL_IDLE;
      left_r <= 7'h00;
      burstClk_r <= 1'b0;
    end else if (ce) begin
      if (hotReset) begin
        state_r <= CCL_IDLE;
        left_r <= 7'h00;
        burstClk_r <= 1'b0;
      end else begin
        state_r <= state_nxt;
        left_r <= left_nxt;
        burstClk_r <= (state_nxt == CCL_RUN);
      end
    end
  end

endmodule // ccl_clk_burst

/* File: ccl_link_cfg_regs.sv */
// Link configuration data and internal error status/mask registers.
// Assumes requests and error pulses on mclk; the control block's
// configuration error arrives from another domain and is synchronised.
//
// Notes on behaviour
// - 32-bit read-write data word, reset zero, drives data to control block.
// - Control bit 1 read-write, reset 0, drives the transfer start output.
// - Control bit 0 read-write, reset 0, requests a configuration transfer.
// - Uncorrectable status bit 11 sets on receive buffer overflow.
// - Uncorrectable bits 9 and 8 set on the two config/transmit parity paths.
// - Transmit packet parity sets bit 7 and that packet is dropped.
// - Uncorrectable bit 6 sets on application uncorrectable error report.
// - Uncorrectable bit 5 sets on config error rise in link config mode.
// - Bits 4, 3, 2 set on data link, receive path, buffer input parity.
// - Bits 1 and 0 set on retry and receive buffer uncorrectable ECC.
// - Unmasked errors are forwarded; status clears by writing one; sticky.
// - Uncorrectable mask resets to one except bit 5, which resets to zero, and bit 6, which has no mask bit.
// - Correctable bit 5 sets on config error in link config mode.
// - Correctable bits 1 and 0 set on ECC errors; status resets zero.
// - Correctable mask bits 6, 1, 0 reset to one, bit 5 to zero.
// - Link configuration mode routes incoming packets to configuration space.
// - Each data write emits programmed clock count; zero means 64.
module ccl_link_cfg_regs (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic hotReset,
  input wire ccl_pkg::ccl_req_t req,
  output logic [31:0] rdData_r,
  output logic rdValid_r,
  input wire logic linkConfigurationMode,
  input wire logic [ccl_pkg::NUMCLK_W-1:0] clocksPerDataWrite,
  input wire logic controlBlockConfigError,
  input wire ccl_pkg::ccl_evt_t evt,
  output logic [31:0] configDataOut_r,
  output logic transferStartFlag_r,
  output logic programmingRequest_r,
  output logic configClock_r,
  output logic routeToConfigSpace_r,
  output logic txTlpDrop_r,
  output logic uncorrErrReport_r,
  output logic corrErrReport_r
);
  import ccl_pkg::*;

  // -------------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------------

  // Matches an access index against one register index.
  function automatic logic hits(input logic [3:0] idx,
                                input logic [3:0] reg_idx);
    hits = (idx == reg_idx);
  endfunction

  // Merges write data into a register through a byte lane and bit mask.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [31:0] laneMask,
                                        input logic [31:0] bits);
    logic [31:0] sel;
    sel = laneMask & bits;
    merge = (old & ~sel) | (wdat & sel);
  endfunction

  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  logic [31:0] cfgData_r;
  logic [31:0] cfgData_nxt;
  logic [31:0] progCtl_r;
  logic [31:0] progCtl_nxt;
  logic [31:0] uncStat_r;
  logic [31:0] uncStat_nxt;
  logic [31:0] uncMask_r;
  logic [31:0] uncMask_nxt;
  logic [31:0] corStat_r;
  logic [31:0] corStat_nxt;
  logic [31:0] corMask_r;
  logic [31:0] corMask_nxt;
  logic [31:0] laneMask;
  logic [31:0] rdMux;
  logic [31:0] uncEvt;
  logic [31:0] corEvt;
  logic [31:0] uncClr;
  logic [31:0] corClr;
  logic cfgErrMeta_r;
  logic cfgErrSync_r;
  logic cfgErrPrev_r;
  logic cfgErrRise;
  logic linkCfgErr;
  logic wrData;
  logic wrProg;
  logic wrUncStat;
  logic wrUncMask;
  logic wrCorStat;
  logic wrCorMask;
  logic uncFwd;
  logic corFwd;

  // -------------------------------------------------------------------
  // Byte lanes
  // -------------------------------------------------------------------

  // Each byte enable opens its eight data bits.
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : gLane
      assign laneMask[8*lane +: 8] = {8{req.byteEn[lane]}};
    end
  endgenerate

  // -------------------------------------------------------------------
  // Write decode
  // -------------------------------------------------------------------

  // Write strobes per register, qualified by the clock enable.
  assign wrData = ce && req.wrEn && hits(req.idx, IDX_CFG_DATA);
  assign wrProg = ce && req.wrEn && hits(req.idx, IDX_PROG_CTL);
  assign wrUncStat = ce && req.wrEn && hits(req.idx, IDX_UNC_STAT);
  assign wrUncMask = ce && req.wrEn && hits(req.idx, IDX_UNC_MASK);
  assign wrCorStat = ce && req.wrEn && hits(req.idx, IDX_COR_STAT);
  assign wrCorMask = ce && req.wrEn && hits(req.idx, IDX_COR_MASK);

  // -------------------------------------------------------------------
  // Control block configuration error
  // -------------------------------------------------------------------

  // Two-stage synchroniser; only the second stage feeds logic.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfgErrMeta_r <= 1'b0;
      cfgErrSync_r <= 1'b0;
      cfgErrPrev_r <= 1'b0;
    end else if (ce) begin
      cfgErrMeta_r <= controlBlockConfigError;
      cfgErrSync_r <= cfgErrMeta_r;
      cfgErrPrev_r <= cfgErrSync_r;
    end
  end

  // A rising edge seen while link configuration mode is on.
  assign cfgErrRise = cfgErrSync_r & ~cfgErrPrev_r;
  assign linkCfgErr = cfgErrRise & linkConfigurationMode;

  // -------------------------------------------------------------------
  // Error event vectors
  // -------------------------------------------------------------------

  // Uncorrectable events placed at their status positions.
  always_comb begin
    uncEvt = 32'h0000_0000;
    uncEvt[UNC_RX_OVF_BIT] = evt.rxOverflow;
    uncEvt[UNC_CFG_TX_PAR_BIT] = evt.cfgTxParity;
    uncEvt[UNC_TX_CFG_PAR_BIT] = evt.txCfgParity;
    uncEvt[UNC_TX_TLP_PAR_BIT] = evt.txTlpParity;
    uncEvt[UNC_APP_BIT] = evt.appUncorr;
    uncEvt[UNC_LINK_CFG_BIT] = linkCfgErr;
    uncEvt[UNC_TX_DLL_PAR_BIT] = evt.txDllParity;
    uncEvt[UNC_RX_CFG_PAR_BIT] = evt.rxCfgParity;
    uncEvt[UNC_RX_BUF_PAR_BIT] = evt.rxBufParity;
    uncEvt[UNC_RETRY_ECC_BIT] = evt.retryUncEcc;
    uncEvt[UNC_RX_ECC_BIT] = evt.rxUncEcc;
  end

  // Correctable events; the application report has a mask but no status.
  always_comb begin
    corEvt = 32'h0000_0000;
    corEvt[COR_LINK_CFG_BIT] = linkCfgErr;
    corEvt[COR_RETRY_ECC_BIT] = evt.retryCorEcc;
    corEvt[COR_RX_ECC_BIT] = evt.rxCorEcc;
  end

  // -------------------------------------------------------------------
  // Next register values
  // -------------------------------------------------------------------

  // Write-one-to-clear masks, limited to lanes and implemented bits.
  assign uncClr = wrUncStat ? (req.wrData & laneMask & UNC_STAT_BITS) :
                  32'h0000_0000;
  assign corClr = wrCorStat ? (req.wrData & laneMask & COR_STAT_BITS) :
                  32'h0000_0000;

  // A new event in the clearing cycle keeps its bit set.
  assign uncStat_nxt = ((uncStat_r & ~uncClr) | uncEvt) &
                       UNC_STAT_BITS;
  assign corStat_nxt = ((corStat_r & ~corClr) | corEvt) &
                       COR_STAT_BITS;

  // Plain read-write registers.
  assign cfgData_nxt = wrData ?
      merge(cfgData_r, req.wrData, laneMask, 32'hFFFF_FFFF) :
      cfgData_r;
  assign progCtl_nxt = wrProg ?
      merge(progCtl_r, req.wrData, laneMask, PROG_CTL_BITS) :
      progCtl_r;
  assign uncMask_nxt = wrUncMask ?
      merge(uncMask_r, req.wrData, laneMask, UNC_MASK_BITS) :
      uncMask_r;
  assign corMask_nxt = wrCorMask ?
      merge(corMask_r, req.wrData, laneMask, COR_MASK_BITS) :
      corMask_r;

  // -------------------------------------------------------------------
  // Non-sticky registers
  // -------------------------------------------------------------------

  // Data word and programming control also clear on a hot reset.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfgData_r <= CFG_DATA_RST;
      progCtl_r <= PROG_CTL_RST;
    end else if (ce) begin
      if (hotReset) begin
        cfgData_r <= CFG_DATA_RST;
        progCtl_r <= PROG_CTL_RST;
      end else begin
        cfgData_r <= cfgData_nxt;
        progCtl_r <= progCtl_nxt;
      end
    end
  end

  // -------------------------------------------------------------------
  // Sticky registers
  // -------------------------------------------------------------------

  // Status and masks ignore hot reset; only the cold reset restores them.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      uncStat_r <= STAT_RST;
      uncMask_r <= UNC_MASK_RST;
      corStat_r <= STAT_RST;
      corMask_r <= COR_MASK_RST;
    end else if (ce) begin
      uncStat_r <= uncStat_nxt;
      uncMask_r <= uncMask_nxt;
      corStat_r <= corStat_nxt;
      corMask_r <= corMask_nxt;
    end
  end

  // -------------------------------------------------------------------
  // Error forwarding
  // -------------------------------------------------------------------

  // A set mask bit keeps that error from being forwarded.
  assign uncFwd = |(uncEvt & ~uncMask_r);
  assign corFwd = |(corEvt & ~corMask_r) |
                  (evt.appCorr & ~corMask_r[COR_APP_BIT]);

  // Registered report pulses, packet drop and routing outputs.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      uncorrErrReport_r <= 1'b0;
      corrErrReport_r <= 1'b0;
      txTlpDrop_r <= 1'b0;
      routeToConfigSpace_r <= 1'b0;
    end else if (ce) begin
      uncorrErrReport_r <= uncFwd;
      corrErrReport_r <= corFwd;
      txTlpDrop_r <= evt.txTlpParity;
      routeToConfigSpace_r <= linkConfigurationMode;
    end
  end

  // -------------------------------------------------------------------
  // Outputs to the configuration control block
  // -------------------------------------------------------------------

  // Direct register views; these are the flops themselves.
  assign configDataOut_r = cfgData_r;
  assign transferStartFlag_r = progCtl_r[PROG_START_BIT];
  assign programmingRequest_r = progCtl_r[PROG_REQ_BIT];

  // Clock burst for every write of the data word.
  ccl_clk_burst uBurst (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .hotReset(hotReset),
    .start(wrData),
    .clocksPerDataWrite(clocksPerDataWrite),
    .burstClk_r(configClock_r)
  );

  // -------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------

  // Read selection; unmapped indices read as zero.
  always_comb begin
    case (req.idx)
      IDX_CFG_DATA: rdMux = cfgData_r;
      IDX_PROG_CTL: rdMux = progCtl_r & PROG_CTL_BITS;
      IDX_UNC_STAT: rdMux = uncStat_r;
      IDX_UNC_MASK: rdMux = uncMask_r;
      IDX_COR_STAT: rdMux = corStat_r;
      IDX_COR_MASK: rdMux = corMask_r;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Read data and its valid strobe one cycle after the request.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData_r <= 32'h0000_0000;
      rdValid_r <= 1'b0;
    end else if (ce) begin
      rdValid_r <= req.rdEn;
      if (req.rdEn) begin
        rdData_r <= rdMux;
      end
    end
  end

endmodule // ccl_link_cfg_regs

/* File: ccl_regs_chk.sv */
// Checker for the link configuration and internal error registers.
// Assumes it is bound to the top module and sees only its ports.
module ccl_regs_chk
  import ccl_pkg::*;
(
  input logic mclk,
  input logic rstn,
  input logic ce,
  input logic hotReset,
  input ccl_req_t req,
  input logic [31:0] rdData_r,
  input logic rdValid_r,
  input logic linkConfigurationMode,
  input logic [7:0] clocksPerDataWrite,
  input ccl_evt_t evt,
  input logic [31:0] configDataOut_r,
  input logic transferStartFlag_r,
  input logic programmingRequest_r,
  input logic configClock_r,
  input logic routeToConfigSpace_r,
  input logic txTlpDrop_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic dataWr;
  logic ctlWr;
  logic [6:0] expN_r;
  logic [6:0] run_r;
  // Writes that the block must take at this edge.
  assign dataWr = ce && req.wrEn && !hotReset && req.idx == IDX_CFG_DATA;
  assign ctlWr = ce && req.wrEn && !hotReset && req.idx == IDX_PROG_CTL
    && req.byteEn[0];
  // Loaded burst length and high cycles seen since the last data write.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      expN_r <= 7'h00;
      run_r <= 7'h00;
    end else if (ce) begin
      if (dataWr) begin
        expN_r <= (clocksPerDataWrite[5:0] == 6'h00) ? 7'h40 :
          {1'b0, clocksPerDataWrite[5:0]};
      end
      run_r <= dataWr ? 7'h00 : run_r + {6'h00, configClock_r};
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  data_follow_a: assert property (
    dataWr && req.byteEn == 4'hF |=> configDataOut_r == $past(req.wrData))
    else $error("data word output wrong");
  start_flag_a: assert property (
    ctlWr |=> transferStartFlag_r == $past(req.wrData[1]))
    else $error("start flag output wrong");
  prog_req_a: assert property (
    ctlWr |=> programmingRequest_r == $past(req.wrData[0]))
    else $error("programming request output wrong");
  tlp_drop_a: assert property (
    ce && evt.txTlpParity |=> txTlpDrop_r)
    else $error("packet drop missing");
  route_mode_a: assert property (
    ce |=> routeToConfigSpace_r == $past(linkConfigurationMode))
    else $error("routing does not follow mode");
  rd_valid_a: assert property (
    ce |=> rdValid_r == $past(req.rdEn))
    else $error("read valid wrong");
  reserved_rd_a: assert property (
    ce && req.rdEn && req.idx != IDX_CFG_DATA |=> rdData_r[31:12] == 20'h0)
    else $error("reserved bits read nonzero");
  hot_clear_a: assert property (
    ce && hotReset |=> configDataOut_r == 32'h0 && !programmingRequest_r
      && !transferStartFlag_r && !configClock_r)
    else $error("hot reset left link state");
  burst_start_a: assert property (
    dataWr |=> configClock_r)
    else $error("burst did not start");
  burst_len_a: assert property (
    $fell(configClock_r) && !$past(hotReset) |-> run_r == expN_r)
    else $error("burst length wrong");
endmodule // ccl_regs_chk

/* File: ccl_ctl_model.sv */
// Model of the configuration control block beyond the register block.
// Assumes the data word and clock burst come from the register block.
module ccl_ctl_model (
  input logic mclk,
  input logic [31:0] dataIn,
  input logic clkIn,
  input logic raiseErr,
  output logic cfgErr,
  output logic [15:0] clkCount,
  output logic [31:0] lastData
);
  timeunit 1ns;
  timeprecision 1ns;
  // Start idle with no clocks counted and no error.
  initial begin
    clkCount = 16'h0000;
    cfgErr = 1'b0;
  end
  // Counts each configuration clock and keeps the word it carried.
  // It never acts on the error status, which is for observation only.
  always @(posedge mclk) begin
    if (clkIn) begin
      clkCount <= clkCount + 16'h0001;
      lastData <= dataIn;
    end
  end
  // The error level moves off the clock grid, as its source is unrelated.
  always @(raiseErr) cfgErr <= #7 raiseErr;
endmodule // ccl_ctl_model

/* File: tb.sv */
// Self-checking bench for the link configuration register block.
// Assumes the checker and control block model are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ccl_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic hotReset = 1'b0;
  logic linkConfigurationMode = 1'b0;
  logic raiseErr = 1'b0;
  logic [7:0] clocksPerDataWrite = 8'h00;
  ccl_req_t req = '{byteEn: 4'hF, default: '0};
  ccl_evt_t evt = '0;
  logic [31:0] rdData_r, configDataOut_r, lastData, rv, d;
  logic rdValid_r, transferStartFlag_r, programmingRequest_r, configClock_r;
  logic routeToConfigSpace_r, txTlpDrop_r, uncorrErrReport_r;
  logic corrErrReport_r, controlBlockConfigError;
  logic [15:0] clkCount, c0;
  logic [5:0] n;
  logic [31:0] rstVal [7] = '{32'h0, 32'h0, 32'h0, UNC_MASK_RST, 32'h0,
    COR_MASK_RST, 32'h0};
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  ccl_link_cfg_regs dut (.mclk, .rstn, .ce, .hotReset, .req, .rdData_r,
    .rdValid_r, .linkConfigurationMode, .clocksPerDataWrite,
    .controlBlockConfigError, .evt, .configDataOut_r, .transferStartFlag_r,
    .programmingRequest_r, .configClock_r, .routeToConfigSpace_r,
    .txTlpDrop_r, .uncorrErrReport_r, .corrErrReport_r);
  ccl_ctl_model model (.mclk, .dataIn(configDataOut_r),
    .clkIn(configClock_r), .raiseErr, .cfgErr(controlBlockConfigError),
    .clkCount, .lastData);
  // ------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ------------------------------------------------------------
  always #20 mclk = ~mclk;
  // Cuts a hang short and reports it as a failure.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    req.wrEn <= 1'b1;
    req.idx <= idx;
    req.wrData <= wd;
    @(posedge mclk);
    req.wrEn <= 1'b0;
  endtask
  // A read is taken at one edge and answered in the next cycle.
  task automatic rd(input logic [3:0] idx, output logic [31:0] rdv);
    @(posedge mclk);
    req.rdEn <= 1'b1;
    req.idx <= idx;
    @(posedge mclk);
    req.rdEn <= 1'b0;
    #1;
    chk({31'h0, rdValid_r}, 32'h1);
    rdv = rdData_r;
  endtask
  task automatic pulse(input ccl_evt_t e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= '0;
    #1;
  endtask
  // Uncorrectable status bit set by event k of the event struct.
  function automatic logic [31:0] uncOf(input int k);
    int pos[13] = '{0, 0, 0, 0, 1, 2, 3, 4, 6, 7, 8, 9, 11};
    return (k > 2) ? 32'h1 << pos[k] : 32'h0;
  endfunction
  // Correctable ECC events sit on bits 1 and 0; the application one has none.
  function automatic logic [31:0] corOf(input int k);
    return (k == 1 || k == 2) ? 32'(k) : 32'h0;
  endfunction
  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(4));
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(4'(i), rv);
      chk(rv, rstVal[i]);
    end
    $display("test reset_values done");
    // Data word with burst lengths 0, 1 and random, upper count bits random.
    for (int i = 0; i < 4; i++) begin
      n = (i < 2) ? 6'(i) : 6'($urandom);
      d = $urandom;
      c0 = clkCount;
      clocksPerDataWrite <= {2'($urandom), n};
      wr(IDX_CFG_DATA, d);
      repeat (70) @(posedge mclk);
      chk(32'(clkCount - c0), (n == 6'h0) ? 32'h40 : 32'(n));
      chk(lastData, d);
      rd(IDX_CFG_DATA, rv);
      chk(rv, d);
    end
    $display("test data_word done");
    for (int v = 0; v < 4; v++) begin
      wr(IDX_PROG_CTL, ($urandom & 32'hFFFFFFFC) | 32'(v));
      rd(IDX_PROG_CTL, rv);
      chk(rv, 32'(v));
      chk({30'h0, transferStartFlag_r, programmingRequest_r},
        32'(v));
    end
    $display("test programming_control done");
    wr(IDX_UNC_MASK, 32'hFFFFFFFF);
    rd(IDX_UNC_MASK, rv);
    chk(rv, UNC_MASK_BITS);
    wr(IDX_COR_MASK, 32'hFFFFFFFF);
    rd(IDX_COR_MASK, rv);
    chk(rv, COR_MASK_BITS);
    // Every event masked except the application uncorrectable one, then unmasked: status, report and clearing.
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 13; k++) begin
        pulse(ccl_evt_t'(13'h0001 << k));
        chk({31'h0, uncorrErrReport_r},
          {31'h0, k > 2 && (p == 1 || k == 8)});
        chk({31'h0, corrErrReport_r}, {31'h0, p == 1 && k < 3});
        rd(IDX_UNC_STAT, rv);
        chk(rv, uncOf(k));
        rd(IDX_COR_STAT, rv);
        chk(rv, corOf(k));
        wr(IDX_UNC_STAT, 32'hFFFFFFFF);
        wr(IDX_COR_STAT, 32'hFFFFFFFF);
        rd(IDX_UNC_STAT, rv);
        chk(rv, 32'h0);
      end
      wr(IDX_UNC_MASK, 32'h0);
      wr(IDX_COR_MASK, 32'h0);
    end
    $display("test error_events done");
    // Configuration error counts only in link configuration mode.
    for (int m = 1; m >= 0; m--) begin
      linkConfigurationMode <= m[0];
      raiseErr = 1'b1;
      repeat (8) @(posedge mclk);
      raiseErr = 1'b0;
      repeat (8) @(posedge mclk);
      rd(IDX_UNC_STAT, rv);
      chk(rv, m ? 32'h20 : 32'h0);
      rd(IDX_COR_STAT, rv);
      chk(rv, m ? 32'h20 : 32'h0);
      wr(IDX_UNC_STAT, 32'hFFFFFFFF);
      wr(IDX_COR_STAT, 32'hFFFFFFFF);
    end
    $display("test config_error done");
    wr(IDX_CFG_DATA, $urandom);
    wr(IDX_PROG_CTL, 32'h3);
    pulse(ccl_evt_t'(13'h1000));
    @(posedge mclk);
    hotReset <= 1'b1;
    @(posedge mclk);
    hotReset <= 1'b0;
    rd(IDX_CFG_DATA, rv);
    chk(rv, 32'h0);
    rd(IDX_PROG_CTL, rv);
    chk(rv, 32'h0);
    rd(IDX_UNC_STAT, rv);
    chk(rv, 32'h800);
    rd(IDX_UNC_MASK, rv);
    chk(rv, 32'h0);
    $display("test hot_reset done");
    // An event wins over a clear in the same cycle.
    fork
      pulse(ccl_evt_t'(13'h0008));
      wr(IDX_UNC_STAT, 32'hFFFFFFFF);
    join
    rd(IDX_UNC_STAT, rv);
    chk(rv, 32'h1);
    // With the clock enable low, neither a write nor an event is taken.
    ce <= 1'b0;
    wr(IDX_CFG_DATA, 32'hA5A5A5A5);
    pulse(ccl_evt_t'(13'h1000));
    ce <= 1'b1;
    rd(IDX_CFG_DATA, rv);
    chk(rv, 32'h0);
    rd(IDX_UNC_STAT, rv);
    chk(rv, 32'h1);
    $display("test set_wins_and_enable done");
    results();
  end
endmodule // tb
bind ccl_link_cfg_regs ccl_regs_chk chk_i (.mclk, .rstn, .ce, .hotReset,
  .req, .rdData_r, .rdValid_r, .linkConfigurationMode, .clocksPerDataWrite,
  .evt, .configDataOut_r, .transferStartFlag_r, .programmingRequest_r,
  .configClock_r, .routeToConfigSpace_r, .txTlpDrop_r);
